// *** pfsv_defs.svh ***
// Constants for the priority field security view block.
`ifndef PFSV_DEFS_SVH
`define PFSV_DEFS_SVH
`define PFSV_NUM_IRQ        32
`define PFSV_IDX_W          5
`define PFSV_PRIO_W         8
`define PFSV_PRIO_TOP       7
`define PFSV_PRIO_RESET     8'h00
`define PFSV_MASK_8BIT      8'hFF
`define PFSV_MASK_7BIT      8'hFE
`define PFSV_MASK_6BIT      8'hFC
`define PFSV_MASK_5BIT      8'hF8
`define PFSV_IDLE_PRIO      8'hFF
`endif

// *** pfsv_pkg.sv ***
// Types shared by the priority field security view block.
`default_nettype none
package pfsv_pkg;
  typedef enum logic [1:0] {
    PFSV_GRP0,
    PFSV_GRP1_SEC,
    PFSV_GRP1_NS
  } pfsv_group_t;
  typedef enum logic [1:0] {
    PFSV_BITS8,
    PFSV_BITS7,
    PFSV_BITS6,
    PFSV_BITS5
  } pfsv_impl_t;
endpackage : pfsv_pkg
`default_nettype wire

// *** pfsv_prio_mem.sv ***
// Priority field storage with a registered read port.
`timescale 1ns/1ps
`default_nettype none
`include "pfsv_defs.svh"
module pfsv_prio_mem (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire logic                       wr_en,
  input  wire logic [`PFSV_IDX_W-1:0]     wr_idx,
  input  wire logic [`PFSV_PRIO_W-1:0]    wr_data,
  input  wire logic [`PFSV_IDX_W-1:0]     rd_idx,
  output logic      [`PFSV_PRIO_W-1:0]    rd_data,
  output logic      [`PFSV_NUM_IRQ*`PFSV_PRIO_W-1:0] all_prio
);
  logic [`PFSV_PRIO_W-1:0] mem_reg  [`PFSV_NUM_IRQ];
  logic [`PFSV_PRIO_W-1:0] mem_next [`PFSV_NUM_IRQ];
  logic [`PFSV_PRIO_W-1:0] rd_next;

  // Next contents: one field written per cycle.
  always_comb begin
    for (int i = 0; i < `PFSV_NUM_IRQ; i++) begin
      mem_next[i] = (wr_en && wr_idx == i[`PFSV_IDX_W-1:0]) ? wr_data : mem_reg[i];
      all_prio[i*`PFSV_PRIO_W +: `PFSV_PRIO_W] = mem_reg[i];
    end
    rd_next = mem_reg[rd_idx];
  end

  // Register storage and read data.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      for (int i = 0; i < `PFSV_NUM_IRQ; i++) begin
        mem_reg[i] <= `PFSV_PRIO_RESET;
      end
      rd_data <= `PFSV_PRIO_RESET;
    end else begin
      for (int i = 0; i < `PFSV_NUM_IRQ; i++) begin
        mem_reg[i] <= mem_next[i];
      end
      rd_data <= rd_next;
    end
  end
endmodule : pfsv_prio_mem
`default_nettype wire

// *** pfsv_top.sv ***
// Priority field views for Secure and Non-secure accesses, arbitration and virtual signalling.
`timescale 1ns/1ps
`default_nettype none
`include "pfsv_defs.svh"

// Notes on behaviour
// - While the priority mask has bit 7 clear, Non-secure reads of priority fields return zero and writes are dropped.
// - While the running priority has bit 7 clear, Non-secure reads of priority fields return zero.
// - With eight bits implemented, Secure reads show 0 to 255 and Non-secure reads show even values up to 254.
// - With seven bits, Secure reads show even values and Non-secure reads show multiples of four up to 252.
// - With six bits reads step by four and eight; with five bits by eight to 248 and sixteen to 240.
// - Group 0 and Secure Group 1 priorities are never shown to Non-secure accesses.
// - A priority rewrite of a pending enabled interrupt neither loses it nor delivers it twice.
// - A priority update reaches arbitration within a bounded time after the write.
// - Writing all ones and reading back returns only the implemented bits.
// - Virtual Group 0 interrupts are signalled on the virtual fast interrupt line.
// - Virtual Group 1 interrupts are signalled on the virtual normal interrupt line.
// - A Non-secure write to a Non-secure Group 1 field is shifted right by one with bit 7 forced to one.
// - Unimplemented low bits of every priority field read as zero and drop written values.
module pfsv_top (
  input  wire logic                       mclk,
  input  wire logic                       reset_n,
  input  wire pfsv_pkg::pfsv_impl_t       impl_bits,
  input  wire logic [`PFSV_PRIO_W-1:0]    cpu_priority_mask,
  input  wire logic [`PFSV_PRIO_W-1:0]    cpu_running_priority,
  input  wire logic                       acc_valid,
  input  wire logic                       acc_write,
  input  wire logic                       acc_nonsecure,
  input  wire logic [`PFSV_IDX_W-1:0]     acc_idx,
  input  wire logic [`PFSV_PRIO_W-1:0]    acc_wdata,
  output logic                            acc_rvalid,
  output logic      [`PFSV_PRIO_W-1:0]    acc_rdata,
  input  wire logic [`PFSV_NUM_IRQ-1:0]   irq_group0,
  input  wire logic [`PFSV_NUM_IRQ-1:0]   irq_ns_group1,
  input  wire logic [`PFSV_NUM_IRQ-1:0]   irq_enable,
  input  wire logic [`PFSV_NUM_IRQ-1:0]   irq_pending,
  output logic                            hp_valid,
  output logic      [`PFSV_IDX_W-1:0]     hp_idx,
  output logic      [`PFSV_PRIO_W-1:0]    hp_prio,
  input  wire logic                       virq_group0_pend,
  input  wire logic                       virq_group1_pend,
  output logic                            virt_fiq,
  output logic                            virt_irq
);
  import pfsv_pkg::*;

  // ------------------------------------------------------------
  // Helper functions
  // ------------------------------------------------------------

  // Mask of implemented priority bits for the configured width.
  function automatic logic [`PFSV_PRIO_W-1:0] impl_mask(input pfsv_impl_t b);
    unique case (b)
      PFSV_BITS8: impl_mask = `PFSV_MASK_8BIT;
      PFSV_BITS7: impl_mask = `PFSV_MASK_7BIT;
      PFSV_BITS6: impl_mask = `PFSV_MASK_6BIT;
      PFSV_BITS5: impl_mask = `PFSV_MASK_5BIT;
    endcase
  endfunction : impl_mask

  // Group of an interrupt from its two group inputs.
  function automatic pfsv_group_t irq_group(input logic g0, input logic ns1);
    if (g0) begin
      irq_group = PFSV_GRP0;
    end else if (ns1) begin
      irq_group = PFSV_GRP1_NS;
    end else begin
      irq_group = PFSV_GRP1_SEC;
    end
  endfunction : irq_group

  // ------------------------------------------------------------
  // Access decode
  // ------------------------------------------------------------
  logic [`PFSV_PRIO_W-1:0] mask;
  pfsv_group_t             acc_grp;
  logic                    ns_hidden_wr;
  logic                    ns_hidden_rd;
  logic                    mem_wr_en;
  logic [`PFSV_PRIO_W-1:0] mem_wdata;
  logic [`PFSV_PRIO_W-1:0] mem_rdata;
  logic [`PFSV_NUM_IRQ*`PFSV_PRIO_W-1:0] all_prio;

  // Write gating and translation of the written value.
  always_comb begin
    mask    = impl_mask(impl_bits);
    acc_grp = irq_group(irq_group0[acc_idx], irq_ns_group1[acc_idx]);
    // Non-secure writes are dropped on a Secure-half mask or a Secure-owned field.
    ns_hidden_wr = !cpu_priority_mask[`PFSV_PRIO_TOP]
                   || acc_grp != PFSV_GRP1_NS;
    mem_wr_en = acc_valid && acc_write && !(acc_nonsecure && ns_hidden_wr);
    if (acc_nonsecure) begin
      mem_wdata = {1'b1, acc_wdata[`PFSV_PRIO_W-1:1]} & mask;
    end else begin
      mem_wdata = acc_wdata & mask;
    end
  end

  pfsv_prio_mem u_mem (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .wr_en    (mem_wr_en),
    .wr_idx   (acc_idx),
    .wr_data  (mem_wdata),
    .rd_idx   (acc_idx),
    .rd_data  (mem_rdata),
    .all_prio (all_prio)
  );

  // ------------------------------------------------------------
  // Read view
  // ------------------------------------------------------------
  logic                    rd_pend_reg;
  logic                    rd_pend_next;
  logic                    rd_ns_reg;
  logic                    rd_ns_next;
  logic                    rd_hide_reg;
  logic                    rd_hide_next;
  logic                    rvalid_reg;
  logic                    rvalid_next;
  logic [`PFSV_PRIO_W-1:0] rdata_reg;
  logic [`PFSV_PRIO_W-1:0] rdata_next;

  // Capture the read request, then present the view one cycle after memory data.
  always_comb begin
    ns_hidden_rd = !cpu_priority_mask[`PFSV_PRIO_TOP]
                   || !cpu_running_priority[`PFSV_PRIO_TOP]
                   || acc_grp != PFSV_GRP1_NS;
    rd_pend_next = acc_valid && !acc_write;
    rd_ns_next   = acc_nonsecure;
    rd_hide_next = acc_nonsecure && ns_hidden_rd;
    rvalid_next  = rd_pend_reg;
    rdata_next   = rdata_reg;
    if (rd_pend_reg) begin
      if (rd_hide_reg) begin
        rdata_next = '0;
      end else if (rd_ns_reg) begin
        rdata_next = {mem_rdata[`PFSV_PRIO_W-2:0], 1'b0};
      end else begin
        rdata_next = mem_rdata;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      rd_pend_reg <= 1'b0;
      rd_ns_reg   <= 1'b0;
      rd_hide_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= `PFSV_PRIO_RESET;
    end else begin
      rd_pend_reg <= rd_pend_next;
      rd_ns_reg   <= rd_ns_next;
      rd_hide_reg <= rd_hide_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
    end
  end

  assign acc_rvalid = rvalid_reg;
  assign acc_rdata  = rdata_reg;

  // ------------------------------------------------------------
  // Arbitration
  // ------------------------------------------------------------
  logic                    hp_valid_reg;
  logic                    hp_valid_next;
  logic [`PFSV_IDX_W-1:0]  hp_idx_reg;
  logic [`PFSV_IDX_W-1:0]  hp_idx_next;
  logic [`PFSV_PRIO_W-1:0] hp_prio_reg;
  logic [`PFSV_PRIO_W-1:0] hp_prio_next;

  // Pick the lowest priority value among enabled pending interrupts from stored fields.
  // Pending state is never touched here, so a rewrite cannot drop or repeat an interrupt.
  always_comb begin
    logic [`PFSV_PRIO_W-1:0] p;
    p             = '0;
    hp_valid_next = 1'b0;
    hp_idx_next   = '0;
    hp_prio_next  = `PFSV_IDLE_PRIO;
    for (int i = 0; i < `PFSV_NUM_IRQ; i++) begin
      p = all_prio[i*`PFSV_PRIO_W +: `PFSV_PRIO_W];
      if (irq_enable[i] && irq_pending[i] && (!hp_valid_next || p < hp_prio_next)) begin
        hp_valid_next = 1'b1;
        hp_idx_next   = i[`PFSV_IDX_W-1:0];
        hp_prio_next  = p;
      end
    end
  end

  // Result registered every cycle: new priority counts two edges after the write.
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      hp_valid_reg <= 1'b0;
      hp_idx_reg   <= '0;
      hp_prio_reg  <= `PFSV_IDLE_PRIO;
    end else begin
      hp_valid_reg <= hp_valid_next;
      hp_idx_reg   <= hp_idx_next;
      hp_prio_reg  <= hp_prio_next;
    end
  end

  assign hp_valid = hp_valid_reg;
  assign hp_idx   = hp_idx_reg;
  assign hp_prio  = hp_prio_reg;

  // ------------------------------------------------------------
  // Virtual interrupt lines
  // ------------------------------------------------------------
  logic vfiq_reg;
  logic vfiq_next;
  logic virq_reg;
  logic virq_next;

  // Group 0 goes to the fast line, Group 1 to the normal line.
  always_comb begin
    vfiq_next = virq_group0_pend;
    virq_next = virq_group1_pend;
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      vfiq_reg <= 1'b0;
      virq_reg <= 1'b0;
    end else begin
      vfiq_reg <= vfiq_next;
      virq_reg <= virq_next;
    end
  end

  assign virt_fiq = vfiq_reg;
  assign virt_irq = virq_reg;
endmodule : pfsv_top
`default_nettype wire

// *** pfsv_monitor.sv ***
// Assertion checker for the priority field access port and virtual lines.
`timescale 1ns/1ps
`default_nettype none
module pfsv_monitor (
  input wire logic                 mclk,
  input wire logic                 reset_n,
  input wire pfsv_pkg::pfsv_impl_t impl_bits,
  input wire logic [7:0]           cpu_priority_mask,
  input wire logic [7:0]           cpu_running_priority,
  input wire logic                 acc_valid,
  input wire logic                 acc_write,
  input wire logic                 acc_nonsecure,
  input wire logic [4:0]           acc_idx,
  input wire logic                 acc_rvalid,
  input wire logic [7:0]           acc_rdata,
  input wire logic [31:0]          irq_group0,
  input wire logic [31:0]          irq_ns_group1,
  input wire logic                 virq_group0_pend,
  input wire logic                 virq_group1_pend,
  input wire logic                 virt_fiq,
  input wire logic                 virt_irq
);
  import pfsv_pkg::*;
  // Read requests and the mask of implemented priority bits.
  wire logic rd_req = acc_valid && !acc_write;
  wire logic ns_rd = rd_req && acc_nonsecure;
  wire logic [7:0] imask = 8'hFF << impl_bits;
  // Field addressed by the access belongs to Group 0 or Secure Group 1.
  wire logic sec_fld = irq_group0[acc_idx] || !irq_ns_group1[acc_idx];
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_read_latency: assert property (rd_req |-> ##2 acc_rvalid)
    else $error("read answer missing");
  chk_mask_hides: assert property (ns_rd && !cpu_priority_mask[7] |-> ##2 acc_rdata == 8'h00)
    else $error("masked read not zero");
  chk_running_hides: assert property (ns_rd && !cpu_running_priority[7] |-> ##2 acc_rdata == 8'h00)
    else $error("running read not zero");
  chk_group_hides: assert property (ns_rd && sec_fld |-> ##2 acc_rdata == 8'h00)
    else $error("secure field shown");
  chk_ns_lsb_zero: assert property (acc_rvalid && $past(acc_nonsecure, 2) |-> !acc_rdata[0])
    else $error("odd nonsecure read");
  chk_impl_bits: assert property (rd_req && !acc_nonsecure |-> ##2 (acc_rdata & ~imask) == 8'h00)
    else $error("unimplemented bits set");
  chk_fiq_follow: assert property ($past(reset_n) |-> virt_fiq == $past(virq_group0_pend))
    else $error("fast line wrong");
  chk_irq_follow: assert property ($past(reset_n) |-> virt_irq == $past(virq_group1_pend))
    else $error("normal line wrong");
  cover property (ns_rd && !cpu_priority_mask[7]);
  cover property (ns_rd && !cpu_running_priority[7]);
  cover property (virt_fiq && virt_irq);
endmodule : pfsv_monitor
bind pfsv_top pfsv_monitor u_mon (.mclk, .reset_n, .impl_bits, .cpu_priority_mask, .cpu_running_priority,
  .acc_valid, .acc_write, .acc_nonsecure, .acc_idx, .acc_rvalid, .acc_rdata, .irq_group0, .irq_ns_group1,
  .virq_group0_pend, .virq_group1_pend, .virt_fiq, .virt_irq);
`default_nettype wire

// *** pfsv_sw_model.sv ***
// Software agent that issues priority field accesses.
`timescale 1ns/1ps
`default_nettype none
module pfsv_sw_model (
  input  wire logic       mclk,
  output var  logic       acc_valid,
  output var  logic       acc_write,
  output var  logic       acc_nonsecure,
  output var  logic [4:0] acc_idx,
  output var  logic [7:0] acc_wdata,
  input  wire logic       acc_rvalid,
  input  wire logic [7:0] acc_rdata
);
  // Idle state of the access lines.
  initial begin
    acc_valid = 1'b0;
    acc_write = 1'b0;
    acc_nonsecure = 1'b0;
    acc_idx = 5'h00;
    acc_wdata = 8'h00;
  end
  // One single-cycle access; on release the index and data lines are inverted so stale values are never relied on.
  task automatic issue(input logic wr, input logic ns, input logic [4:0] idx, input logic [7:0] wd);
    @(negedge mclk);
    acc_valid = 1'b1;
    acc_write = wr;
    acc_nonsecure = ns;
    acc_idx = idx;
    acc_wdata = wd;
    @(negedge mclk);
    acc_valid = 1'b0;
    acc_idx = ~idx;
    acc_wdata = ~wd;
  endtask : issue
  // A read that waits a bounded time for the answer pulse.
  task automatic rd(input logic ns, input logic [4:0] idx, output logic [7:0] d);
    int n;
    issue(1'b0, ns, idx, 8'h00);
    n = 0;
    while (acc_rvalid !== 1'b1 && n < 8) begin
      @(negedge mclk);
      n++;
    end
    d = (acc_rvalid === 1'b1) ? acc_rdata : 8'hXX;
  endtask : rd
endmodule : pfsv_sw_model
`default_nettype wire

// *** priority_field_security_view_tb.sv ***
// Self-checking testbench for the priority field security view block.
`timescale 1ns/1ps
`default_nettype none
module priority_field_security_view_tb;
  import pfsv_pkg::*;
  logic mclk, reset_n, acc_valid, acc_write, acc_nonsecure, acc_rvalid, hp_valid;
  logic virq_group0_pend, virq_group1_pend, virt_fiq, virt_irq;
  pfsv_impl_t impl_bits;
  logic [4:0] acc_idx, hp_idx;
  logic [7:0] cpu_priority_mask, cpu_running_priority, acc_wdata, acc_rdata, hp_prio, rd;
  logic [31:0] irq_group0, irq_ns_group1, irq_enable, irq_pending;
  int bad_count = 0;
  int samples_checked = 0;
  pfsv_top u_dut (.mclk, .reset_n, .impl_bits, .cpu_priority_mask, .cpu_running_priority, .acc_valid,
    .acc_write, .acc_nonsecure, .acc_idx, .acc_wdata, .acc_rvalid, .acc_rdata, .irq_group0, .irq_ns_group1,
    .irq_enable, .irq_pending, .hp_valid, .hp_idx, .hp_prio, .virq_group0_pend, .virq_group1_pend,
    .virt_fiq, .virt_irq);
  pfsv_sw_model u_sw (.mclk, .acc_valid, .acc_write, .acc_nonsecure, .acc_idx, .acc_wdata, .acc_rvalid,
    .acc_rdata);
  // Clock of 4 ns period.
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // Compares one value and counts it.
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  // Prints the counts and the verdict, then stops.
  task automatic close_out;
    $display("checked=%0d failed=%0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  // Probe with all ones at every width; both views of field 8.
  task automatic t_views;
    logic [7:0] m;
    for (int i = 0; i < 4; i++) begin
      impl_bits = pfsv_impl_t'(i);
      m = 8'hFF << i;
      u_sw.issue(1'b1, 1'b0, 5'h08, 8'hFF);
      u_sw.rd(1'b0, 5'h08, rd);
      check(rd, m);
      u_sw.rd(1'b1, 5'h08, rd);
      check(rd, {m[6:0], 1'b0});
    end
  endtask : t_views
  // Nonsecure write is shifted with the top bit forced, then trimmed.
  task automatic t_ns_write;
    u_sw.issue(1'b1, 1'b1, 5'h09, 8'h46);
    u_sw.rd(1'b0, 5'h09, rd);
    check(rd, 8'hA0);
    impl_bits = PFSV_BITS8;
    u_sw.issue(1'b1, 1'b1, 5'h09, 8'h46);
    u_sw.rd(1'b0, 5'h09, rd);
    check(rd, 8'hA3);
  endtask : t_ns_write
  // Mask, running priority and group hide fields from nonsecure accesses.
  task automatic t_hide;
    cpu_priority_mask = 8'h7F;
    u_sw.issue(1'b1, 1'b1, 5'h09, 8'h00);
    u_sw.rd(1'b0, 5'h09, rd);
    check(rd, 8'hA3);
    u_sw.rd(1'b1, 5'h09, rd);
    check(rd, 8'h00);
    cpu_priority_mask = 8'hFF;
    cpu_running_priority = 8'h40;
    u_sw.rd(1'b1, 5'h09, rd);
    check(rd, 8'h00);
    cpu_running_priority = 8'hFF;
    u_sw.issue(1'b1, 1'b0, 5'h01, 8'h30);
    u_sw.issue(1'b1, 1'b1, 5'h01, 8'hFF);
    u_sw.rd(1'b0, 5'h01, rd);
    check(rd, 8'h30);
    u_sw.rd(1'b1, 5'h01, rd);
    check(rd, 8'h00);
    u_sw.issue(1'b1, 1'b0, 5'h04, 8'h40);
    u_sw.rd(1'b1, 5'h04, rd);
    check(rd, 8'h00);
  endtask : t_hide
  // Arbitration picks the lowest value and follows a rewrite promptly.
  task automatic t_arb;
    u_sw.issue(1'b1, 1'b0, 5'h0A, 8'hA0);
    u_sw.issue(1'b1, 1'b0, 5'h05, 8'h50);
    irq_enable = 32'h0000_0420;
    irq_pending = 32'h0000_0420;
    repeat (3) @(negedge mclk);
    check(hp_prio, 8'h50);
    u_sw.issue(1'b1, 1'b0, 5'h0A, 8'h20);
    @(negedge mclk);
    check({3'h0, hp_idx}, 8'h0A);
    check(hp_prio, 8'h20);
    check({7'h00, hp_valid}, 8'h01);
    irq_pending = 32'h0000_0000;
    repeat (2) @(negedge mclk);
    check(hp_prio, 8'hFF);
    check({7'h00, hp_valid}, 8'h00);
  endtask : t_arb
  // Virtual pend inputs appear on the matching lines one edge later.
  task automatic t_virt;
    for (int i = 0; i < 4; i++) begin
      virq_group0_pend = i[0];
      virq_group1_pend = i[1];
      @(negedge mclk);
      check({6'h00, virt_irq, virt_fiq}, 8'(i));
    end
  endtask : t_virt
  // Mid-run reset returns hp_prio, the virtual lines and stored field 9 to their reset values.
  task automatic t_reset;
    irq_pending = 32'h0000_0020;
    repeat (2) @(negedge mclk);
    reset_n = 1'b0;
    repeat (2) @(negedge mclk);
    reset_n = 1'b1;
    check(hp_prio, 8'hFF);
    check({6'h00, virt_irq, virt_fiq}, 8'h00);
    u_sw.rd(1'b0, 5'h09, rd);
    check(rd, 8'h00);
  endtask : t_reset
  // Main sequence.
  initial begin
    reset_n = 1'b0;
    impl_bits = PFSV_BITS8;
    cpu_priority_mask = 8'hFF;
    cpu_running_priority = 8'hFF;
    irq_group0 = 32'h0000_000F;
    irq_ns_group1 = 32'hFFFF_FF00;
    irq_enable = 32'h0000_0000;
    irq_pending = 32'h0000_0000;
    virq_group0_pend = 1'b0;
    virq_group1_pend = 1'b0;
    repeat (20) @(negedge mclk);
    reset_n = 1'b1;
    t_views();
    t_ns_write();
    t_hide();
    t_arb();
    t_virt();
    t_reset();
    close_out();
  end
  // Watchdog far beyond the hundred or so cycles the scenarios need.
  initial begin
    #80000;
    bad_count++;
    close_out();
  end
endmodule : priority_field_security_view_tb
`default_nettype wire
